// *** logic/adcsc_top.sv ***
`timescale 1ns/100ps
// How it works
// - comparator output latch precharged while precharge control low, idle when high
// - negative comparator input grounded while ground enable is true
// - three-bit negative select and eight-bit positive select steer the inputs
// - supply voltage is the converter reference while its select is true
// - gain power-on powers stages when high; its rise starts settle timing
module adcsc_top
  import adcsc_pkg::*;
(
  input wire logic sys_clk,              // 50 MHz system clock
  input wire logic sys_rst,              // asynchronous reset, high
  input wire logic [7:0] s_axi_awaddr,   // write address
  input wire logic s_axi_awvalid,        // write address valid
  output logic s_axi_awready,            // write address ready
  input wire logic [31:0] s_axi_wdata,   // write data
  input wire logic [3:0] s_axi_wstrb,    // write byte enables
  input wire logic s_axi_wvalid,         // write data valid
  output logic s_axi_wready,             // write data ready
  output logic [1:0] s_axi_bresp,        // write response
  output logic s_axi_bvalid,             // write response valid
  input wire logic s_axi_bready,         // write response ready
  input wire logic [7:0] s_axi_araddr,   // read address
  input wire logic s_axi_arvalid,        // read address valid
  output logic s_axi_arready,            // read address ready
  output logic [31:0] s_axi_rdata,       // read data
  output logic [1:0] s_axi_rresp,        // read response
  output logic s_axi_rvalid,             // read data valid
  input wire logic s_axi_rready,         // read data ready
  input wire logic compIn,               // raw comparator result, asynchronous
  output adcsc_ctrl_t adcCtrl,           // applied converter controls
  output adcsc_mux_t adcMux,             // applied input selects
  output adcsc_gain_t gainSetting,       // decoded gain of the gain stages
  output logic latchPrecharge,           // comparator latch precharge, high active
  output logic settleWindow              // inside the settle-assist window
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic awHeld_reg, wHeld_reg, bValid_reg, arReady_reg, rValid_reg;
  logic awReady_reg, wReady_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg, rData_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bResp_reg, rResp_reg;
  logic [13:0] stageCtrl_reg, stageCtrl_next;
  logic [10:0] stageMux_reg, stageMux_next;
  adcsc_ctrl_t actCtrl_reg;
  adcsc_mux_t actMux_reg;
  adcsc_gain_t gain_reg;
  logic precharge_reg, refused_reg, compObs_reg;
  logic [2:0] compSync_reg;
  logic gainClkPrev_reg, powerPrev_reg, settle_reg;
  logic [1:0] settleCnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // write side decode
  wire doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
  wire [31:0] wMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}}, {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
  wire [31:0] ctrlMerged = ({18'h00000, stageCtrl_reg} & ~wMask) | (wData_reg & wMask);
  wire [31:0] muxMerged = ({21'h000000, stageMux_reg} & ~wMask) | (wData_reg & wMask);
  wire hitCtrl = awAddr_reg == OFS_CTRL;
  wire hitMux = awAddr_reg == OFS_MUX;
  wire hitApply = awAddr_reg == OFS_APPLY;
  wire wrMapped = hitCtrl || hitMux || hitApply;
  wire applyGo = doWrite && hitApply && wStrb_reg[0] && wData_reg[APPLY_GO_BIT];
  wire refuseClr = doWrite && hitApply && wStrb_reg[0] && wData_reg[APPLY_CLR_BIT];

  // staged words follow byte enables; only an apply moves them to the pins
  assign stageCtrl_next = (doWrite && hitCtrl) ? ctrlMerged[CTRL_W-1:0] : stageCtrl_reg;
  assign stageMux_next = (doWrite && hitMux) ? muxMerged[MUX_W-1:0] : stageMux_reg;

  ////////////////////////////////////////////////////////////////////////////
  // negative-input source check on the staged set
  wire adcsc_ctrl_t stagedCtrl = adcsc_ctrl_t'(stageCtrl_reg);
  wire [1:0] negSources = 2'(stagedCtrl.neg_pin_path) + 2'(stagedCtrl.neg_bandgap)
                          + 2'(stagedCtrl.negative_ground_enable);
  wire contention = negSources != 2'h1;
  wire applyOk = applyGo && !contention;

  // gain decode, twentyfold wins if both are set
  wire adcsc_gain_t gainNext = stagedCtrl.gain_x20_enable ? GAIN_X20 :
                               stagedCtrl.gain_x10_enable ? GAIN_X10 : GAIN_UNITY;

  ////////////////////////////////////////////////////////////////////////////
  // bus write channels: address and data taken in either order
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awReady_reg <= 1'b1;
      wReady_reg <= 1'b1;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
    end else begin
      // ready flops mirror the held flags so the ports come straight from a register
      if (s_axi_awvalid && !awHeld_reg) begin
        awHeld_reg <= 1'b1;
        awReady_reg <= 1'b0;
        awAddr_reg <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_reg <= 1'b0;
        awReady_reg <= 1'b1;
      end
      if (s_axi_wvalid && !wHeld_reg) begin
        wHeld_reg <= 1'b1;
        wReady_reg <= 1'b0;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_reg <= 1'b0;
        wReady_reg <= 1'b1;
      end
    end
  end

  // write response, unmapped or read-only words answer with an error
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      bResp_reg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_reg <= 1'b0;
    end
  end

  // ready is high only while the channel holds nothing, so no item is dropped
  assign s_axi_awready = awReady_reg;
  assign s_axi_wready = wReady_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // staged and applied control words
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stageCtrl_reg <= CTRL_RST;
      stageMux_reg <= MUX_RST;
      actCtrl_reg <= adcsc_ctrl_t'(CTRL_RST);
      actMux_reg <= adcsc_mux_t'(MUX_RST);
      gain_reg <= GAIN_UNITY;
    end else begin
      stageCtrl_reg <= stageCtrl_next;
      stageMux_reg <= stageMux_next;
      if (applyOk) begin
        actCtrl_reg <= stagedCtrl;
        actMux_reg <= adcsc_mux_t'(stageMux_reg);
        gain_reg <= gainNext;
      end
    end
  end

  // refused apply is sticky; a new refusal beats a clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      refused_reg <= 1'b0;
    end else if (applyGo && contention) begin
      refused_reg <= 1'b1;
    end else if (refuseClr) begin
      refused_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator result: three stages, a change counts when the last two agree
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compSync_reg <= 3'h0;
    end else begin
      compSync_reg <= {compSync_reg[1:0], compIn};
    end
  end

  // precharge while the control is low clears the observed result
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      precharge_reg <= 1'b0;
      compObs_reg <= 1'b0;
    end else begin
      precharge_reg <= !actCtrl_reg.latch_precharge_n;
      if (!actCtrl_reg.latch_precharge_n) begin
        compObs_reg <= 1'b0;
      end else if (compSync_reg[2] == compSync_reg[1]) begin
        compObs_reg <= compSync_reg[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settle window: gain clock is a scan bit, so its edges are seen as levels
  wire powerRise = actCtrl_reg.gain_power_on && !powerPrev_reg;
  wire gainClkRise = actCtrl_reg.gain_clock && !gainClkPrev_reg;

  // power-on rise opens the window, it closes after two gain periods
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerPrev_reg <= 1'b0;
      gainClkPrev_reg <= 1'b0;
      settle_reg <= 1'b0;
      settleCnt_reg <= 2'h0;
    end else begin
      powerPrev_reg <= actCtrl_reg.gain_power_on;
      gainClkPrev_reg <= actCtrl_reg.gain_clock;
      if (powerRise) begin
        settle_reg <= 1'b1;
        settleCnt_reg <= 2'h0;
      end else if (!actCtrl_reg.gain_power_on) begin
        settle_reg <= 1'b0;
      end else if (settle_reg && gainClkRise) begin
        settleCnt_reg <= settleCnt_reg + 2'h1;
        settle_reg <= (settleCnt_reg + 2'h1) != SETTLE_PERIODS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side
  wire [31:0] statusWord = {22'h000000, settleCnt_reg, 3'h0, precharge_reg, settle_reg,
                            refused_reg, contention, compObs_reg};
  wire rdCtrl = s_axi_araddr == OFS_CTRL;
  wire rdMux = s_axi_araddr == OFS_MUX;
  wire rdApply = s_axi_araddr == OFS_APPLY;
  wire rdStatus = s_axi_araddr == OFS_STATUS;
  wire rdActCtrl = s_axi_araddr == OFS_ACT_CTRL;
  wire rdActMux = s_axi_araddr == OFS_ACT_MUX;
  wire rdMapped = rdCtrl || rdMux || rdApply || rdStatus || rdActCtrl || rdActMux;
  wire [31:0] rdWord = rdCtrl ? {18'h00000, stageCtrl_reg} :
                       rdMux ? {21'h000000, stageMux_reg} :
                       rdStatus ? statusWord :
                       rdActCtrl ? {18'h00000, actCtrl_reg} :
                       rdActMux ? {21'h000000, actMux_reg} : 32'h00000000;
  wire arTake = s_axi_arvalid && arReady_reg;

  // one read at a time; address ready drops until the data is taken
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arReady_reg <= 1'b1;
      rValid_reg <= 1'b0;
      rData_reg <= 32'h00000000;
      rResp_reg <= RESP_OKAY;
    end else if (arTake) begin
      arReady_reg <= 1'b0;
      rValid_reg <= 1'b1;
      rData_reg <= rdWord;
      rResp_reg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_reg && s_axi_rready) begin
      rValid_reg <= 1'b0;
      arReady_reg <= 1'b1;
    end
  end

  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // converter-facing outputs, each straight from a flip-flop
  // ground, bandgap reference, supply reference ride adcCtrl
  assign adcCtrl = actCtrl_reg;
  assign adcMux = actMux_reg;
  assign gainSetting = gain_reg;
  assign latchPrecharge = precharge_reg;
  assign settleWindow = settle_reg;

endmodule

// *** logic/adcsc_pkg.sv ***
package adcsc_pkg;

  // converter control fields, one scan-driven bit each
  typedef struct packed {
    logic neg_pin_path;           // pin route to the negative sample-hold input
    logic neg_bandgap;            // bandgap route to the negative input
    logic gain_clock;             // scan-driven clock of the gain stages
    logic gain_power_on;
    logic supply_ref_select;
    logic settle_assist;
    logic switchcap_test_enable;
    logic latch_precharge_n;
    logic gain_passgate_enable;
    logic internal_ref_enable;
    logic sample_hold;            // low samples, high holds
    logic negative_ground_enable;
    logic gain_x20_enable;
    logic gain_x10_enable;
  } adcsc_ctrl_t;

  // input mux selects
  typedef struct packed {
    logic [2:0] neg_sel;
    logic [7:0] pos_sel;
  } adcsc_mux_t;

  typedef enum logic [1:0] {GAIN_UNITY, GAIN_X10, GAIN_X20} adcsc_gain_t;

  localparam int CTRL_W = 14;
  localparam int MUX_W = 11;

  // byte addresses of the register words
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MUX = 8'h04;
  localparam logic [7:0] OFS_APPLY = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_ACT_CTRL = 8'h10;
  localparam logic [7:0] OFS_ACT_MUX = 8'h14;

  // apply word fields
  localparam int APPLY_GO_BIT = 0;
  localparam int APPLY_CLR_BIT = 1;

  // status word fields
  localparam int STAT_COMP_BIT = 0;
  localparam int STAT_CONT_BIT = 1;
  localparam int STAT_REFUSE_BIT = 2;
  localparam int STAT_SETTLE_BIT = 3;
  localparam int STAT_PRECHARGE_BIT = 4;
  localparam int STAT_CNT_LSB = 8;

  // idle values: hold, pass-gate, precharge off and mux bit 0 high
  localparam logic [13:0] CTRL_RST = 14'h0068;
  localparam logic [10:0] MUX_RST = 11'h001;

  // gain-clock periods of settle assist after power-on
  localparam logic [1:0] SETTLE_PERIODS = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** verif/adcsc_assertions.sv ***
`timescale 1ns/100ps
module adcsc_checker
  import adcsc_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // async reset
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire adcsc_ctrl_t adcCtrl, // applied controls
  input wire adcsc_mux_t adcMux, // applied selects
  input wire adcsc_gain_t gainSetting, // decoded gain
  input wire logic latchPrecharge, // latch precharging
  input wire logic settleWindow // settle window
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // latch precharge is one cycle behind its active-low control
  precharge_on_a: assert property (!adcCtrl.latch_precharge_n |=> latchPrecharge)
    else $error("latch precharge not raised");
  precharge_off_a: assert property (adcCtrl.latch_precharge_n |=> !latchPrecharge)
    else $error("latch precharge not released");
  // stable enables must show their gain; x20 wins over x10
  gain_decode_a: assert property ($stable(adcCtrl) |-> gainSetting == (adcCtrl.gain_x20_enable ? GAIN_X20 :
    adcCtrl.gain_x10_enable ? GAIN_X10 : GAIN_UNITY)) else $error("gain setting wrong");
  // a new applied set never drives two negative paths at once
  one_source_a: assert property ($changed(adcCtrl) |-> $onehot({adcCtrl.neg_pin_path,
    adcCtrl.neg_bandgap, adcCtrl.negative_ground_enable})) else $error("negative input contention");
  // applied controls and selects move only with the apply response
  apply_sync_a: assert property ($changed(adcCtrl) || $changed(adcMux) |-> $rose(s_axi_bvalid))
    else $error("controls changed outside apply");
  settle_open_a: assert property ($rose(adcCtrl.gain_power_on) |=> settleWindow)
    else $error("settle window not opened");
  settle_off_a: assert property (!adcCtrl.gain_power_on |=> !settleWindow)
    else $error("settle window open without power");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  cover property ($rose(settleWindow));
  cover property (latchPrecharge);
  cover property (gainSetting == GAIN_X20);
endmodule

// *** verif/adcsc_conv_model.sv ***
`timescale 1ns/100ps
module adcsc_conv_model
  import adcsc_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire adcsc_ctrl_t adcCtrl, // applied controls
  input wire logic analogHigh, // input above the dac level
  output logic compIn = 1'b0 // comparator result
);
  // precharge active low
  // sampling or precharging leaves no valid result, so the line toggles
  always @(posedge sys_clk) begin
    if (adcCtrl.sample_hold && adcCtrl.latch_precharge_n) begin
      compIn <= analogHigh;
    end else begin
      compIn <= ~compIn;
    end
  end
endmodule

// *** verif/adc_scan_control_cells_tb.sv ***
`timescale 1ns/100ps
module adc_scan_control_cells_tb
  import adcsc_pkg::*;
;
  logic sysClk = 1'b0, sysRst = 1'b1, awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0, analogHigh = 1'b0;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'hF;
  logic awReady, wReady, bValid, arReady, rValid, compIn, latchPrecharge, settleWindow;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  adcsc_ctrl_t adcCtrl;
  adcsc_mux_t adcMux;
  adcsc_gain_t gainSetting;
  int checks = 0, mismatches = 0, seed = 32'h4F6D;
  adcsc_top dut (.sys_clk(sysClk), .sys_rst(sysRst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .compIn(compIn), .adcCtrl(adcCtrl),
    .adcMux(adcMux), .gainSetting(gainSetting), .latchPrecharge(latchPrecharge), .settleWindow(settleWindow));
  adcsc_conv_model conv (.sys_clk(sysClk), .adcCtrl(adcCtrl), .analogHigh(analogHigh), .compIn(compIn));
  ////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    forever #10 sysClk = ~sysClk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // each channel released only at the edge that takes it
  // no cycle limit here: only the watchdog ends a wait
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sysClk);
    awAddr <= a; wData <= d; awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
    do begin
      @(posedge sysClk);
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    r = bResp;
    bReady <= 1'b0;
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge sysClk);
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    do begin
      @(posedge sysClk);
      if (arReady === 1'b1) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    d = rData;
    rReady <= 1'b0;
  endtask
  task automatic apply(input adcsc_ctrl_t c);
    logic [1:0] r;
    axiWrite(OFS_CTRL, {18'h0, c}, r);
    axiWrite(OFS_APPLY, 32'h1, r);
    chk(r, RESP_OKAY);
  endtask
  function automatic adcsc_gain_t expGain(input adcsc_ctrl_t c);
    return c.gain_x20_enable ? GAIN_X20 : (c.gain_x10_enable ? GAIN_X10 : GAIN_UNITY);
  endfunction
  // one negative path, hold follows the gain clock while gain power is on
  function automatic adcsc_ctrl_t legalCtrl(input logic [31:0] r);
    adcsc_ctrl_t c;
    c = r[13:0];
    {c.neg_pin_path, c.neg_bandgap, c.negative_ground_enable} = 3'h1 << (r[20:16] % 3);
    if (c.gain_power_on) c.sample_hold = c.gain_clock;
    return c;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
  initial begin
    logic [31:0] rd;
    logic [1:0] rsp;
    adcsc_ctrl_t c;
    adcsc_mux_t m;
    repeat (6) @(posedge sysClk);
    sysRst <= 1'b0;
    chk(adcCtrl, CTRL_RST);
    chk(adcMux, MUX_RST);
    chk({gainSetting, latchPrecharge, settleWindow}, {GAIN_UNITY, 2'h0});
    $display("test reset done");
    // idle staging selects no negative path, so apply must be refused
    axiWrite(OFS_APPLY, 32'h1, rsp);
    axiRead(OFS_STATUS, rd);
    chk({rd[STAT_REFUSE_BIT], adcCtrl}, {1'b1, CTRL_RST});
    axiWrite(OFS_APPLY, 32'h2, rsp);
    axiRead(OFS_STATUS, rd);
    chk(rd[STAT_REFUSE_BIT], 1'b0);
    axiWrite(8'h18, 32'h1, rsp);
    chk(rsp, RESP_SLVERR);
    axiWrite(OFS_STATUS, 32'h1, rsp);
    chk(rsp, RESP_SLVERR);
    // read response holds until the next read is taken
    axiRead(8'h18, rd);
    chk(rResp, RESP_SLVERR);
    // a single byte enable touches only the low byte of the staged word
    wStrb <= 4'h1;
    axiWrite(OFS_CTRL, 32'h0000FFFF, rsp);
    wStrb <= 4'hF;
    axiRead(OFS_CTRL, rd);
    chk(rd, {18'h0, CTRL_RST[13:8], 8'hFF});
    chk(rResp, RESP_OKAY);
    $display("test refusal done");
    // random legal sets; first has both gains, second all mux bits
    for (int i = 0; i < 12; i++) begin
      c = legalCtrl($random(seed));
      rd = $random(seed);
      m = (i == 1) ? 11'h7FF : rd[10:0];
      if (i == 0) {c.gain_x20_enable, c.gain_x10_enable} = 2'h3;
      axiWrite(OFS_MUX, {21'h0, m}, rsp);
      apply(c);
      chk({adcCtrl, adcMux}, {c, m});
      @(posedge sysClk);
      chk({gainSetting, latchPrecharge}, {expGain(c), !c.latch_precharge_n});
      axiRead(OFS_ACT_CTRL, rd);
      chk(rd[13:0], c);
      axiRead(OFS_ACT_MUX, rd);
      chk(rd[10:0], m);
    end
    $display("test random apply done");
    c = CTRL_RST;
    c.negative_ground_enable = 1'b1;
    for (int k = 0; k < 3; k++) begin
      analogHigh <= k[0] | k[1];
      c.latch_precharge_n = !k[1];
      apply(c);
      repeat (6) @(posedge sysClk);
      axiRead(OFS_STATUS, rd);
      chk({rd[STAT_PRECHARGE_BIT], rd[STAT_COMP_BIT]}, {k[1], k[0]});
    end
    $display("test comparator done");
    // settle assist held through the window
    c.latch_precharge_n = 1'b1;
    c.gain_power_on = 1'b1;
    c.settle_assist = 1'b1;
    for (int k = 0; k < 4; k++) begin
      // gain clock toggled as a scan bit, one apply per level
      c.gain_clock = k[0];
      c.sample_hold = k[0];
      apply(c);
      repeat (2) @(posedge sysClk);
      chk(settleWindow, k != 3);
    end
    $display("test settle done");
    close_out();
  end
endmodule
bind adcsc_top adcsc_checker chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .adcCtrl(adcCtrl), .adcMux(adcMux),
  .gainSetting(gainSetting), .latchPrecharge(latchPrecharge), .settleWindow(settleWindow));
